// ### design/amc_mode_scan_control.sv
// Purpose: mode word decode, scan sequencing and serial result output
// Assumes: converter core answers convStart with one convValid pulse
// Notes:   serial pins are oversampled on clk; sclk must stay well below clk/4
//
// Behaviour
// RULE1: power field drives power mode, external clock
// RULE2: tag bit gives channel then 12-bit result
// RULE3: internal clock always tags results with channel
// RULE4: software start triggers on chip-select rising edge
// RULE5: host rewrites software start for each conversion
// RULE6: scan code zero keeps mode, ignores channel and tag
// RULE7: scan code zero still stores reset, power, start
// RULE8: host may hold data input low idle
// RULE9: manual converts framed channel, outputs next frame
// RULE10: manual is external clock, single, no averaging
// RULE11: repeat stores 4, 8, 12 or 16 results
// RULE12: repeat is internal clock, averaging allowed
// RULE13: standard scan converts 0 up to N
// RULE14: channel select gives last scan channel
// RULE15: scan codes 0..3 decode keep, manual, repeat, standard
// RULE16: bits 10:7 carry channel N
// RULE17: repeat count comes from configuration word
// RULE18: mux switches on thirteenth sclk falling edge
`timescale 1ns/1ps
module amc_mode_scan_control
	import amc_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// serial pins
	input  wire logic             sclk,
	input  wire logic             chipSelectN,
	input  wire logic             din,
	output logic                  dout,
	input  wire logic             convertStartPinN,
	// converter core
	input  wire logic [RES_W-1:0] convData,
	input  wire logic             convValid,
	output logic                  convStart,
	output logic      [CH_W-1:0]  muxChannel,
	output logic      [1:0]       powerMode,
	output logic                  avgEnable,
	output logic                  intClockMode
);
	localparam int PTR_W   = $clog2(DEPTH);
	localparam int MUX_LAG = WORD_W - 1 - int'(MUX_FALL);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	logic [3:0]        pinSync;
	logic              sclkS, csS, dinS, cnvS, sclkD, csD, cnvD;
	logic              sclkRise, sclkFall, frameStart, frameEnd, cnvFall, wordDone;

	// sclk low, select high, data low, start pin high while idle
	amc_sync #(.W(4), .INIT(4'h5)) u_sync (
		.clk     (clk),
		.resetn  (resetn),
		.asyncIn ({sclk, chipSelectN, din, convertStartPinN}),
		.syncOut (pinSync)
	);
	assign {sclkS, csS, dinS, cnvS} = pinSync;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sclkD <= 1'b0;
			csD   <= 1'b1;
			cnvD  <= 1'b1;
		end else begin
			sclkD <= sclkS;
			csD   <= csS;
			cnvD  <= cnvS;
		end
	end

	assign sclkRise   = sclkS & ~sclkD;
	assign sclkFall   = ~sclkS & sclkD;
	assign frameStart = csD & ~csS;
	assign frameEnd   = ~csD & csS;
	assign cnvFall    = cnvD & ~cnvS;

	// ----------------------------------------
	// serial shifter
	// ----------------------------------------
	logic [WORD_W-1:0] shiftIn, next_shiftIn, shiftOut, next_shiftOut, outWord;
	logic [4:0]        bitCnt, next_bitCnt, fallCnt, next_fallCnt;
	logic              next_dout;

	always_comb begin
		next_shiftIn  = shiftIn;
		next_shiftOut = shiftOut;
		next_bitCnt   = bitCnt;
		next_fallCnt  = fallCnt;
		next_dout     = dout;
		if (frameStart) begin
			next_bitCnt   = '0;
			next_fallCnt  = '0;
			next_dout     = outWord[WORD_W-1];
			next_shiftOut = {outWord[WORD_W-2:0], 1'b0};
		end else if (!csS) begin
			if (sclkRise) begin
				next_shiftIn = {shiftIn[WORD_W-2:0], dinS};
				if (bitCnt != BIT_FULL)
					next_bitCnt = bitCnt + 5'h1;
			end
			if (sclkFall) begin
				next_dout     = shiftOut[WORD_W-1];
				next_shiftOut = {shiftOut[WORD_W-2:0], 1'b0};
				if (fallCnt != 5'h1F)
					next_fallCnt = fallCnt + 5'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			shiftIn  <= '0;
			shiftOut <= '0;
			bitCnt   <= '0;
			fallCnt  <= '0;
			dout     <= 1'b0;
		end else begin
			shiftIn  <= next_shiftIn;
			shiftOut <= next_shiftOut;
			bitCnt   <= next_bitCnt;
			fallCnt  <= next_fallCnt;
			dout     <= next_dout;
		end
	end

	// short or aborted frames carry no command
	assign wordDone = frameEnd && (bitCnt == BIT_FULL);

	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	amc_mode_s  cfg, next_cfg;
	logic [1:0] rptSel, next_rptSel;
	logic       next_avgEnable, next_intClockMode, fifoClear, swUsed, trigger;
	logic       avgReq, next_avgReq;
	logic [3:0] code;
	logic [1:0] rstField;

	assign code     = shiftIn[SCAN_MSB:SCAN_LSB];
	assign rstField = shiftIn[RST_MSB:RST_LSB];

	always_comb begin
		next_cfg       = cfg;
		next_rptSel    = rptSel;
		next_avgReq    = avgReq;
		fifoClear      = 1'b0;
		// one write buys one conversion run
		// RULE5 consume start bit
		if (swUsed)
			next_cfg.softwareConvertStart = 1'b0;
		if (wordDone && !shiftIn[REG_SEL_BIT]) begin
			// RULE7 fields stored unless reset-all
			next_cfg.powerSelect          = shiftIn[PM_MSB:PM_LSB];
			next_cfg.softwareConvertStart = shiftIn[SWST_BIT];
			// RULE15 scan code decode
			case (code)
				SCAN_MANUAL, SCAN_REPEAT, SCAN_STDINT: begin
					// RULE16 channel field
					next_cfg.channelSelect    = shiftIn[CHSEL_MSB:CHSEL_LSB];
					next_cfg.channelTagEnable = shiftIn[TAG_BIT];
					next_cfg.mode = (code == SCAN_MANUAL) ? MODE_MANUAL :
					                (code == SCAN_REPEAT) ? MODE_REPEAT : MODE_STDINT;
				end
				// RULE6 keep scan settings
				default: next_cfg.mode = cfg.mode;
			endcase
			fifoClear = (rstField == RST_FIFO) || (rstField == RST_ALL);
			if (rstField == RST_ALL) begin
				next_cfg       = MODE_RST;
				next_rptSel    = '0;
				next_avgReq    = 1'b0;
			end
		end else if (wordDone && code == CFG_ID) begin
			// RULE17 repeat count source
			next_rptSel    = shiftIn[CFG_RPT_MSB:CFG_RPT_LSB];
			next_avgReq    = shiftIn[CFG_AVG_BIT];
		end
		// RULE10 no averaging in manual
		// request survives manual frames, only the flag is masked
		next_avgEnable    = next_avgReq && (next_cfg.mode != MODE_MANUAL);
		next_intClockMode = (next_cfg.mode != MODE_MANUAL);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg          <= MODE_RST;
			rptSel       <= '0;
			avgReq       <= 1'b0;
			avgEnable    <= 1'b0;
			intClockMode <= 1'b0;
			powerMode    <= '0;
		end else begin
			cfg          <= next_cfg;
			rptSel       <= next_rptSel;
			avgReq       <= next_avgReq;
			avgEnable    <= next_avgEnable;
			intClockMode <= next_intClockMode;
			// RULE1 power only in external clock
			powerMode    <= next_intClockMode ? 2'h0 : next_cfg.powerSelect;
		end
	end

	// ----------------------------------------
	// conversion sequencer
	// ----------------------------------------
	amc_seq_e          state, next_state;
	logic [CH_W-1:0]   seqChan, next_seqChan, next_muxChannel, frameChan;
	logic [4:0]        seqLeft, next_seqLeft;
	logic              next_convStart, manPend, next_manPend, push;
	logic [WORD_W-1:0] extResult, next_extResult;

	// RULE4 trigger source select
	assign trigger = intClockMode && (state == SQ_IDLE) &&
	                 (cfg.softwareConvertStart ? frameEnd : cnvFall);
	assign swUsed  = trigger && cfg.softwareConvertStart;
	assign push    = (state == SQ_WAIT) && convValid;
	// channel seen in the current frame, else the stored one
	// at the 13th fall the last bits are not in yet, so fields sit MUX_LAG places lower
	assign frameChan = (!shiftIn[REG_SEL_BIT-MUX_LAG] &&
	                    shiftIn[SCAN_MSB-MUX_LAG:SCAN_LSB-MUX_LAG] == SCAN_MANUAL) ?
	                   shiftIn[CHSEL_MSB-MUX_LAG:CHSEL_LSB-MUX_LAG] : cfg.channelSelect;

	always_comb begin
		next_state      = state;
		next_seqChan    = seqChan;
		next_seqLeft    = seqLeft;
		next_convStart  = 1'b0;
		next_muxChannel = muxChannel;
		next_manPend    = manPend;
		next_extResult  = extResult;
		case (state)
			SQ_IDLE: begin
				if (trigger) begin
					next_state = SQ_START;
					if (cfg.mode == MODE_REPEAT) begin
						// RULE11 repeat count 4..16
						next_seqChan = cfg.channelSelect;
						next_seqLeft = {3'({1'b0, rptSel} + 3'h1), 2'b00};
					end else begin
						// RULE14 last channel from select
						next_seqChan = '0;
						next_seqLeft = 5'({1'b0, cfg.channelSelect} + 5'h01);
					end
				end
			end
			SQ_START: begin
				next_convStart  = 1'b1;
				next_muxChannel = seqChan;
				next_state      = SQ_WAIT;
			end
			SQ_WAIT: begin
				if (convValid) begin
					next_seqLeft = seqLeft - 5'h01;
					// RULE13 ascending channels
					// RULE12 repeat holds channel
					if (cfg.mode == MODE_STDINT)
						next_seqChan = seqChan + 4'h1;
					next_state = (seqLeft == 5'h01) ? SQ_IDLE : SQ_NEXT;
				end
			end
			SQ_NEXT: next_state = SQ_START;
			default: next_state = SQ_IDLE;
		endcase
		if (cfg.mode == MODE_MANUAL) begin
			// RULE18 mux on 13th falling edge
			if (!csS && sclkFall && fallCnt == MUX_FALL)
				next_muxChannel = frameChan;
			// RULE9 convert now, shift out next frame
			if (wordDone) begin
				next_convStart = 1'b1;
				next_manPend   = 1'b1;
			end
			if (manPend && convValid) begin
				next_extResult = {muxChannel, convData};
				next_manPend   = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state      <= SQ_IDLE;
			seqChan    <= '0;
			seqLeft    <= '0;
			convStart  <= 1'b0;
			muxChannel <= '0;
			manPend    <= 1'b0;
			extResult  <= '0;
		end else begin
			state      <= next_state;
			seqChan    <= next_seqChan;
			seqLeft    <= next_seqLeft;
			convStart  <= next_convStart;
			muxChannel <= next_muxChannel;
			manPend    <= next_manPend;
			extResult  <= next_extResult;
		end
	end

	// ----------------------------------------
	// result fifo
	// ----------------------------------------
	logic [WORD_W-1:0] mem [DEPTH];
	logic [PTR_W-1:0]  wrPtr, next_wrPtr, rdPtr, next_rdPtr;
	logic [PTR_W:0]    fifoCount, next_fifoCount;
	logic              doPush, doPop;

	// full fifo drops new results rather than stalling the converter
	assign doPush = push && (fifoCount != (PTR_W+1)'(DEPTH));
	assign doPop  = wordDone && intClockMode && (fifoCount != '0);

	always_comb begin
		next_wrPtr     = wrPtr;
		next_rdPtr     = rdPtr;
		next_fifoCount = fifoCount;
		if (fifoClear) begin
			next_wrPtr     = '0;
			next_rdPtr     = '0;
			next_fifoCount = '0;
		end else begin
			if (doPush)
				next_wrPtr = wrPtr + 1'b1;
			if (doPop)
				next_rdPtr = rdPtr + 1'b1;
			next_fifoCount = fifoCount + (PTR_W+1)'(doPush) - (PTR_W+1)'(doPop);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wrPtr     <= '0;
			rdPtr     <= '0;
			fifoCount <= '0;
		end else begin
			wrPtr     <= next_wrPtr;
			rdPtr     <= next_rdPtr;
			fifoCount <= next_fifoCount;
		end
	end

	always_ff @(posedge clk) begin
		if (doPush && !fifoClear)
			mem[wrPtr] <= {muxChannel, convData};
	end

	// RULE3 internal results always tagged
	// RULE2 tag or left-justified result
	always_comb begin
		if (intClockMode)
			outWord = (fifoCount != '0) ? mem[rdPtr] : '0;
		else if (cfg.channelTagEnable)
			outWord = extResult;
		else
			outWord = {extResult[RES_W-1:0], 4'h0};
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_conv_issue;
		(state == SQ_START) ##1 convStart;
	endsequence

	property p_power_ext;
		intClockMode |-> powerMode == 2'h0;
	endproperty
	a_power_ext: assert property (p_power_ext) else $error("power mode active in internal clock"); // RULE1

	property p_tag_ext;
		frameStart && !intClockMode && cfg.channelTagEnable |=> dout == $past(extResult[WORD_W-1]);
	endproperty
	a_tag_ext: assert property (p_tag_ext) else $error("tagged word does not lead with channel"); // RULE2

	property p_tag_int;
		intClockMode && fifoCount != '0 |-> outWord == mem[rdPtr];
	endproperty
	a_tag_int: assert property (p_tag_int) else $error("internal word not tagged fifo entry"); // RULE3

	property p_sw_start;
		intClockMode && cfg.softwareConvertStart && frameEnd && state == SQ_IDLE |=> s_conv_issue;
	endproperty
	a_sw_start: assert property (p_sw_start) else $error("software start did not convert"); // RULE4

	property p_keep_scan;
		wordDone && !shiftIn[REG_SEL_BIT] && code == SCAN_KEEP && rstField != RST_ALL
			|=> $stable(cfg.mode) && $stable(cfg.channelSelect);
	endproperty
	a_keep_scan: assert property (p_keep_scan) else $error("keep code altered scan settings"); // RULE6

	property p_keep_store;
		wordDone && !shiftIn[REG_SEL_BIT] && code == SCAN_KEEP && rstField != RST_ALL
			|=> cfg.powerSelect == $past(shiftIn[PM_MSB:PM_LSB]);
	endproperty
	a_keep_store: assert property (p_keep_store) else $error("power field not stored"); // RULE7

	property p_repeat_cnt;
		trigger && cfg.mode == MODE_REPEAT
			|=> seqLeft == {3'($past(rptSel) + 3'h1), 2'b00} && seqChan == $past(cfg.channelSelect);
	endproperty
	a_repeat_cnt: assert property (p_repeat_cnt) else $error("repeat count wrong"); // RULE11

	property p_scan_mux;
		(state == SQ_START) |=> convStart && muxChannel == $past(seqChan);
	endproperty
	a_scan_mux: assert property (p_scan_mux) else $error("mux not set at conversion"); // RULE13

	property p_mux_edge;
		cfg.mode == MODE_MANUAL && !csS && sclkFall && fallCnt == MUX_FALL |=> muxChannel == $past(frameChan);
	endproperty
	a_mux_edge: assert property (p_mux_edge) else $error("mux not switched on edge 13"); // RULE18
endmodule

// ### design/amc_pkg.sv
// Purpose: shared constants and types for the mode and scan control block
// Assumes: 16-bit command words, 12-bit results, 4-bit channel numbers
// Notes:   scan codes above 0011 are treated as keep-previous
package amc_pkg;
	localparam int WORD_W = 16;
	localparam int RES_W  = 12;
	localparam int CH_W   = 4;

	// ----------------------------------------
	// command word fields
	// ----------------------------------------
	localparam int REG_SEL_BIT = 15;
	localparam int SCAN_MSB    = 14;
	localparam int SCAN_LSB    = 11;
	localparam int CHSEL_MSB   = 10;
	localparam int CHSEL_LSB   = 7;
	localparam int RST_MSB     = 6;
	localparam int RST_LSB     = 5;
	localparam int PM_MSB      = 4;
	localparam int PM_LSB      = 3;
	localparam int TAG_BIT     = 2;
	localparam int SWST_BIT    = 1;

	localparam logic [3:0] SCAN_KEEP   = 4'h0;
	localparam logic [3:0] SCAN_MANUAL = 4'h1;
	localparam logic [3:0] SCAN_REPEAT = 4'h2;
	localparam logic [3:0] SCAN_STDINT = 4'h3;
	localparam logic [1:0] RST_FIFO    = 2'h1;
	localparam logic [1:0] RST_ALL     = 2'h2;

	// ----------------------------------------
	// configuration word (bit 15 set, id in 14:11)
	// ----------------------------------------
	localparam logic [3:0] CFG_ID      = 4'h0;
	localparam int         CFG_AVG_BIT = 4;
	localparam int         CFG_RPT_MSB = 3;
	localparam int         CFG_RPT_LSB = 2;

	// ----------------------------------------
	// timing and sizes
	// ----------------------------------------
	localparam logic [4:0] BIT_FULL    = 5'h10;
	localparam logic [4:0] MUX_FALL    = 5'h0C;
	localparam int         FIFO_DEPTH  = 16;

	typedef enum logic [2:0] {
		MODE_MANUAL = 3'b001,
		MODE_REPEAT = 3'b010,
		MODE_STDINT = 3'b100
	} amc_mode_e;

	typedef enum logic [3:0] {
		SQ_IDLE  = 4'b0001,
		SQ_START = 4'b0010,
		SQ_WAIT  = 4'b0100,
		SQ_NEXT  = 4'b1000
	} amc_seq_e;

	typedef struct packed {
		amc_mode_e             mode;
		logic [CH_W-1:0]       channelSelect;
		logic [1:0]            powerSelect;
		logic                  channelTagEnable;
		logic                  softwareConvertStart;
	} amc_mode_s;

	localparam amc_mode_s MODE_RST = '{MODE_MANUAL, 4'h0, 2'h0, 1'b0, 1'b0};
endpackage

// ### design/amc_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk
// Notes:   only the second stage may be read
`timescale 1ns/1ps
module amc_sync #(
	parameter int           W    = 4,
	// idle pin levels, so that no false edge follows reset
	parameter logic [W-1:0] INIT = '0
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         resetn,
	// pins and synchronised copies
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);
	logic [W-1:0] stage1;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stage1  <= INIT;
			syncOut <= INIT;
		end else begin
			stage1  <= asyncIn;
			syncOut <= stage1;
		end
	end
endmodule

// ### dv/amc_host_model.sv
// Purpose: serial host that frames 16-bit words into the block
// Assumes: clk runs far faster than sclk
// Notes:   sclk high and low each last 4 clk, above the 3 clk minimum
`timescale 1ns/1ps
module amc_host_model
	import amc_pkg::*;
(
	// clock
	input  wire logic clk,
	// serial pins
	output logic      sclk,
	output logic      chipSelectN,
	output logic      din,
	input  wire logic dout
);
	initial begin
		sclk        = 1'b0;
		chipSelectN = 1'b1;
		din         = 1'b1;
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	// ----------------------------------------
	// one full frame, word out and result in
	// ----------------------------------------
	// zero word keeps mode, channel and tag; clears power and start
	task automatic xfer(input logic [WORD_W-1:0] w, output logic [WORD_W-1:0] r);
		chipSelectN = 1'b0;
		for (int i = WORD_W - 1; i >= 0; i--) begin
			din = w[i];
			step(4);
			r[i] = dout;
			sclk = 1'b1;
			step(4);
			sclk = 1'b0;
		end
		step(4);
		chipSelectN = 1'b1;
		// released line shows no stale level
		din = ~din;
		step(8);
	endtask
endmodule

// ### dv/test_amc_mode_scan_control.sv
// Purpose: self-checking bench for the mode and scan control block
// Assumes: converter core answers each convStart one clk later
// Notes:   core result is a fixed pattern over the channel number
`timescale 1ns/1ps
module test_amc_mode_scan_control;
	import amc_pkg::*;

	logic              clk;
	logic              resetn;
	logic              sclk;
	logic              chipSelectN;
	logic              din;
	logic              dout;
	logic              convertStartPinN;
	logic [RES_W-1:0]  convData;
	logic              convValid;
	logic              convStart;
	logic [CH_W-1:0]   muxChannel;
	logic [1:0]        powerMode;
	logic              avgEnable;
	logic              intClockMode;
	logic [WORD_W-1:0] r;
	logic [CH_W-1:0]   ch;
	logic [CH_W-1:0]   chq[$];
	int                nStarts;
	int                base;
	int                n_errors;
	int                num_checks;

	amc_mode_scan_control amc_mode_scan_control_inst (
		.clk              (clk),
		.resetn           (resetn),
		.sclk             (sclk),
		.chipSelectN      (chipSelectN),
		.din              (din),
		.dout             (dout),
		.convertStartPinN (convertStartPinN),
		.convData         (convData),
		.convValid        (convValid),
		.convStart        (convStart),
		.muxChannel       (muxChannel),
		.powerMode        (powerMode),
		.avgEnable        (avgEnable),
		.intClockMode     (intClockMode)
	);

	amc_host_model amc_host_model_inst (
		.clk         (clk),
		.sclk        (sclk),
		.chipSelectN (chipSelectN),
		.din         (din),
		.dout        (dout)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	function automatic logic [RES_W-1:0] resultOf(input logic [CH_W-1:0] c);
		return {8'hA5, c};
	endfunction

	function automatic logic [WORD_W-1:0] mw(input logic [3:0] scan, input logic [3:0] chan,
		input logic [1:0] rst, input logic [1:0] pwr, input logic tag, input logic sw);
		return {1'b0, scan, chan, rst, pwr, tag, sw, 1'b0};
	endfunction

	function automatic logic [WORD_W-1:0] cw(input logic avg, input logic [1:0] sel);
		return {1'b1, 4'h0, 6'h00, avg, sel, 2'b00};
	endfunction

	// ----------------------------------------
	// converter core stand-in
	// ----------------------------------------
	initial begin
		convData  = 12'h000;
		convValid = 1'b0;
		nStarts   = 0;
	end
	// sampled on the falling edge so registered outputs have settled
	always @(negedge clk) begin
		if (convStart === 1'b1) begin
			ch = muxChannel;
			nStarts++;
			chq.push_back(ch);
			@(posedge clk);
			#2;
			convData  = resultOf(ch);
			convValid = 1'b1;
			@(posedge clk);
			#2;
			convValid = 1'b0;
		end
	end

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// bounded wait for a number of conversions, then settle
	task automatic wait_starts(input int n);
		for (int i = 0; i < 800 && nStarts - base < n; i++)
			amc_host_model_inst.step(1);
		amc_host_model_inst.step(20);
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		#(25 * 40000);
		n_errors++;
		final_report();
	end

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		n_errors         = 0;
		num_checks       = 0;
		resetn           = 1'b0;
		convertStartPinN = 1'b1;
		repeat (3) @(posedge clk);
		#2;
		resetn = 1'b1;
		check("powerMode", 16'(powerMode), 16'h0000);
		check("intClockMode", 16'(intClockMode), 16'h0000);
		amc_host_model_inst.step(4);
		// manual mode, tagged output
		amc_host_model_inst.xfer(mw(4'h1, 4'h5, 2'h0, 2'h1, 1'b1, 1'b0), r);
		check("powerMode", 16'(powerMode), 16'h0001);
		check("muxChannel", 16'(muxChannel), 16'h0005);
		check("intClockMode", 16'(intClockMode), 16'h0000);
		amc_host_model_inst.xfer(16'h0000, r);
		check("tagged word", r, {4'h5, resultOf(4'h5)});
		amc_host_model_inst.xfer(mw(4'h1, 4'h3, 2'h0, 2'h0, 1'b0, 1'b0), r);
		check("manual prior", r, {4'h5, resultOf(4'h5)});
		// keep code: channel and tag ignored, power stored
		amc_host_model_inst.xfer(mw(4'h0, 4'hF, 2'h0, 2'h2, 1'b1, 1'b0), r);
		check("untagged word", r, {resultOf(4'h3), 4'h0});
		check("powerMode", 16'(powerMode), 16'h0002);
		check("muxChannel", 16'(muxChannel), 16'h0003);
		amc_host_model_inst.xfer(16'h0000, r);
		check("kept manual", r, {resultOf(4'h3), 4'h0});
		// repeat mode, every count selection
		for (int s = 0; s < 4; s++) begin
			amc_host_model_inst.xfer(cw(1'b1, 2'(s)), r);
			amc_host_model_inst.xfer(mw(4'h2, 4'h7, RST_FIFO, 2'h1, 1'b0, 1'b0), r);
			check("intClockMode", 16'(intClockMode), 16'h0001);
			check("avgEnable", 16'(avgEnable), 16'h0001);
			check("powerMode", 16'(powerMode), 16'h0000);
			chq.delete();
			base = nStarts;
			convertStartPinN = 1'b0;
			amc_host_model_inst.step(4);
			convertStartPinN = 1'b1;
			wait_starts((s + 1) * 4);
			check("repeat count", 16'(nStarts - base), 16'((s + 1) * 4));
			foreach (chq[i]) check("repeat chan", 16'(chq[i]), 16'h0007);
		end
		for (int i = 0; i < 16; i++) begin
			amc_host_model_inst.xfer(16'h0000, r);
			check("fifo word", r, {4'h7, resultOf(4'h7)});
		end
		amc_host_model_inst.xfer(16'h0000, r);
		check("fifo empty", r, 16'h0000);
		// standard scan by software start
		// start bit written once per conversion run
		amc_host_model_inst.xfer(mw(4'h3, 4'h4, RST_FIFO, 2'h0, 1'b0, 1'b1), r);
		chq.delete();
		base = nStarts;
		amc_host_model_inst.step(50);
		check("no early start", 16'(nStarts - base), 16'h0000);
		amc_host_model_inst.xfer(16'h0000, r);
		wait_starts(5);
		check("scan count", 16'(nStarts - base), 16'h0005);
		foreach (chq[i]) check("scan chan", 16'(chq[i]), 16'(i));
		for (int i = 0; i < 5; i++) begin
			amc_host_model_inst.xfer(16'h0000, r);
			check("scan word", r, {4'(i), resultOf(4'(i))});
		end
		check("one shot", 16'(nStarts - base), 16'h0005);
		amc_host_model_inst.xfer(16'h0000, r);
		check("scan empty", r, 16'h0000);
		// manual forbids averaging and internal clock
		amc_host_model_inst.xfer(mw(4'h1, 4'h2, 2'h0, 2'h0, 1'b0, 1'b0), r);
		check("avgEnable", 16'(avgEnable), 16'h0000);
		check("intClockMode", 16'(intClockMode), 16'h0000);
		// reset-all on an unused code, then an unused code keeps the scan setup
		amc_host_model_inst.xfer(mw(4'h5, 4'h9, RST_ALL, 2'h3, 1'b1, 1'b0), r);
		check("powerMode", 16'(powerMode), 16'h0000);
		amc_host_model_inst.xfer(mw(4'hA, 4'h9, 2'h0, 2'h3, 1'b1, 1'b0), r);
		check("powerMode", 16'(powerMode), 16'h0003);
		check("muxChannel", 16'(muxChannel), 16'h0000);
		amc_host_model_inst.xfer(mw(4'h2, 4'h1, 2'h0, 2'h0, 1'b0, 1'b0), r);
		check("keep ignores tag", r, {resultOf(4'h0), 4'h0});
		check("avgEnable", 16'(avgEnable), 16'h0000);
		check("intClockMode", 16'(intClockMode), 16'h0001);
		final_report();
	end
endmodule
